/* tb/dphr_master_model.sv */
// Network master model issuing single word requests
`timescale 1ns/1ps
module dphr_master_model (
  // Clock
  input wire logic ref_clk,
  // Request side
  output logic req_valid,
  output dphr_pkg::dphr_req_t req,
  input wire logic req_ready,
  // Answer side
  input wire logic resp_valid,
  input wire logic [15:0] resp_rdata,
  input wire dphr_pkg::dphr_status_t resp_status
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // One word transfer; lat counts falling edges from take to answer
  task automatic xfer(input logic wr, input logic [15:0] adr, input logic [15:0] dat,
                      output logic [15:0] rdata, output logic [1:0] st,
                      output int lat, output logic busy);
    int n;
    n = 0;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req = '{write: wr, addr: adr, data: dat};
    while (req_ready !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    @(negedge ref_clk);
    // Released lines show the inverse, never the last value
    req_valid = 1'b0;
    req = ~req;
    busy = req_ready;
    lat = 1;
    while (resp_valid !== 1'b1 && lat < 8) begin
      @(negedge ref_clk);
      lat++;
    end
    rdata = resp_rdata;
    st = resp_status;
  endtask : xfer
endmodule : dphr_master_model

/* tb/testbench.sv */
// Self-checking bench of the drive parameter holding registers
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid;
  dphr_pkg::dphr_req_t req;
  logic req_ready;
  logic resp_valid;
  logic [15:0] resp_rdata;
  dphr_pkg::dphr_status_t resp_status;
  logic [15:0] start_frequency_setting = 16'h0032;
  logic [15:0] maximum_frequency_m1 = 16'h0258;
  logic [15:0] maximum_frequency_m2 = 16'h01F4;
  dphr_pkg::dphr_ctrl_t ctrl;
  int n_fail = 0;
  int check_count = 0;
  logic [15:0] rd;
  logic [1:0] st;
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] REF = 2'h1;

  always #2.5 ref_clk = ~ref_clk;

  dphr_holding_regs dphr_holding_regs_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .resp_status(resp_status), .start_frequency_setting(start_frequency_setting),
    .maximum_frequency_m1(maximum_frequency_m1),
    .maximum_frequency_m2(maximum_frequency_m2), .ctrl(ctrl));
  dphr_master_model dphr_master_model_i (
    .ref_clk(ref_clk), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_status(resp_status));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Transfer with answer spacing checked
  task automatic xfer(input logic wr, input logic [15:0] adr, input logic [15:0] dat);
    int lat;
    logic busy;
    dphr_master_model_i.xfer(wr, adr, dat, rd, st, lat, busy);
    check(16'(lat), 16'h0002);
    check({15'h0000, busy}, 16'h0000);
  endtask : xfer

  task automatic wr_chk(input logic [15:0] adr, input logic [15:0] dat,
                        input logic [1:0] est, input logic [15:0] eval);
    xfer(1'b1, adr, dat);
    check({14'h0000, st}, {14'h0000, est});
    xfer(1'b0, adr, 16'h0000);
    check(rd, eval);
  endtask : wr_chk

  task automatic test_reset_values();
    for (int i = 0; i < dphr_pkg::REG_NUM; i++) begin
      xfer(1'b0, dphr_pkg::REG_ADDR[i], 16'h0000);
      check({14'h0000, st}, 16'h0000);
      check(rd, (dphr_pkg::REG_ADDR[i] == 16'h106C) ? 16'h0064 : 16'h0000);
    end
    $display("reset values done");
  endtask : test_reset_values

  task automatic test_spans();
    logic [15:0] a [24] = '{16'h1051, 16'h1052, 16'h1053, 16'h1054, 16'h1055,
      16'h1056, 16'h105D, 16'h105E, 16'h1060, 16'h1061, 16'h1063, 16'h1064,
      16'h106A, 16'h106B, 16'h106C, 16'h106D, 16'h106E, 16'h106F, 16'h1070, 16'h1073,
      16'h1068, 16'h1069, 16'h1071, 16'h1072};
    logic [15:0] lo [24] = '{16'h0000, 16'h0032, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0002, 16'h0000, 16'h0000};
    logic [15:0] hi [24] = '{16'h0002, 16'h0258, 16'h0032, 16'h0064, 16'h0258,
      16'h0001, 16'h0FA0, 16'h0064, 16'h0FA0, 16'h0064, 16'h0FA0, 16'h0064,
      16'h05DC, 16'h03E8, 16'h270F, 16'h0003, 16'h0001, 16'h03E8, 16'h0002, 16'h03E8,
      16'h0001, 16'h0032, 16'h0005, 16'h0001};
    for (int i = 0; i < 24; i++) begin
      wr_chk(a[i], hi[i], OK, hi[i]);
      wr_chk(a[i], hi[i] + 16'h0001, REF, hi[i]);
      if (lo[i] != 16'h0000) wr_chk(a[i], lo[i] - 16'h0001, REF, hi[i]);
      wr_chk(a[i], lo[i], OK, lo[i]);
    end
    $display("value spans done");
  endtask : test_spans

  task automatic test_codes();
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 16'h106D, 16'(c));
      check({14'h0000, ctrl.pv_source}, 16'(c));
      if (c < 3) begin
        xfer(1'b1, 16'h1051, 16'(c));
        check({14'h0000, ctrl.brake_select}, 16'(c));
        xfer(1'b1, 16'h1070, 16'(c));
        check({14'h0000, ctrl.volt_reg_select}, 16'(c));
      end
      if (c < 2) begin
        xfer(1'b1, 16'h1056, 16'(c));
        check({15'h0000, ctrl.brake_level_sense}, 16'(c));
        xfer(1'b1, 16'h106E, 16'(c));
        check({15'h0000, ctrl.loop_negate}, 16'(c));
        xfer(1'b1, 16'h1068, 16'(c));
        check({15'h0000, ctrl.loop_enable}, 16'(c));
      end
    end
    $display("option codes done");
  endtask : test_codes

  task automatic test_limits();
    wr_chk(16'h105B, 16'h0064, OK, 16'h0064);
    wr_chk(16'h105A, 16'h0063, REF, 16'h0000);
    wr_chk(16'h105A, 16'h0259, REF, 16'h0000);
    wr_chk(16'h105A, 16'h0258, OK, 16'h0258);
    wr_chk(16'h105B, 16'h0031, REF, 16'h0064);
    wr_chk(16'h105B, 16'h0259, REF, 16'h0064);
    wr_chk(16'h105B, 16'h0000, OK, 16'h0000);
    check(ctrl.upper_m1, 16'h0258);
    check(ctrl.lower_m1, 16'h0000);
    wr_chk(16'h1518, 16'h01F5, REF, 16'h0000);
    wr_chk(16'h1518, 16'h00C8, OK, 16'h00C8);
    wr_chk(16'h1517, 16'h00C7, REF, 16'h0000);
    wr_chk(16'h1517, 16'h01F5, REF, 16'h0000);
    wr_chk(16'h1517, 16'h01F4, OK, 16'h01F4);
    wr_chk(16'h1517, 16'h0000, OK, 16'h0000);
    check(ctrl.upper_m2, 16'h0000);
    check(ctrl.lower_m2, 16'h00C8);
    $display("frequency limits done");
  endtask : test_limits

  task automatic test_unmapped_and_reset();
    xfer(1'b0, 16'h1059, 16'h0000);
    check({14'h0000, st}, 16'h0002);
    check(rd, 16'h0000);
    xfer(1'b1, 16'h1074, 16'h0005);
    check({14'h0000, st}, 16'h0002);
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    check(16'(ctrl[72:64]), 16'h0000);
    check(ctrl.upper_m1, 16'h0000);
    wr_chk(16'h1053, 16'h0033, REF, 16'h0000);
    xfer(1'b0, 16'h1052, 16'h0000);
    check(rd, 16'h0000);
    xfer(1'b0, 16'h106C, 16'h0000);
    check(rd, 16'h0064);
    $display("unmapped and second reset done");
  endtask : test_unmapped_and_reset

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    test_reset_values();
    test_spans();
    test_codes();
    test_limits();
    test_unmapped_and_reset();
    give_verdict();
  end

  // About fourteen times the expected run
  initial begin
    #50us;
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule : testbench

/* verilog/dphr_holding_regs.sv */
// Network holding registers for drive braking, limits, loop and voltage settings
//
// Summary of operation
// - Brake select takes code 0 off, 1 on, 2 frequency detect only.
// - Brake onset frequency in 0.1 Hz, from start frequency up to 600.
// - Brake wait time in 0.1 s, 0 to 50, motor coasts meanwhile.
// - Brake force in whole percent, 0 to 100.
// - Brake duration in 0.1 s, 0 to 600.
// - Brake trigger mode: 0 edge sensing, 1 level sensing of brake input.
// - Motor 1 upper limit: lower limit to maximum frequency, zero disables.
// - Motor 2 upper limit: same scaling, own lower limit and maximum.
// - Motor 1 lower limit: start frequency to upper limit, zero disables.
// - Motor 2 lower limit: same scaling, bounded by motor 2 upper limit.
// - Three jump centre words in 0.1 Hz, 0 to 4000.
// - Three jump width words in 0.1 Hz, 0 to 100.
// - Loop integral time in 0.1 s, 0 to 1500.
// - Loop derivative time in 0.1 s, 0 to 1000.
// - Process value scale in hundredths, 1 to 9999.
// - Process value source code 0 to 3.
// - Loop output limit in 0.1 percent, 0 to 1000.
// - Voltage regulation: 0 on, 1 off, 2 on except decelerating.
// - Energy saving tuning in 0.1 percent, 0 to 1000.
`timescale 1ns/1ps
module dphr_holding_regs #(
  parameter int DEPTH = dphr_pkg::REG_NUM
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Network word request
  input wire logic req_valid,
  input wire dphr_pkg::dphr_req_t req,
  output logic req_ready,
  // Network word answer
  output logic resp_valid,
  output logic [15:0] resp_rdata,
  output dphr_pkg::dphr_status_t resp_status,
  // Bounds from neighbouring parameter groups, in 0.1 Hz
  input wire logic [15:0] start_frequency_setting,
  input wire logic [15:0] maximum_frequency_m1,
  input wire logic [15:0] maximum_frequency_m2,
  // Stored settings toward the drive
  output dphr_pkg::dphr_ctrl_t ctrl
);
  generate
    if (DEPTH != dphr_pkg::REG_NUM) begin : g_depth_bad
      $error("DEPTH must equal the number of mapped words");
    end
  endgenerate

  dphr_pkg::dphr_state_t state_reg;
  dphr_pkg::dphr_state_t state_next;
  dphr_pkg::dphr_req_t req_q_reg;
  dphr_pkg::dphr_limits_t lim;
  logic take;
  logic chk_hit;
  logic chk_ok;
  logic [dphr_pkg::IDX_W-1:0] chk_idx;
  logic commit;
  logic rd_fetch;
  logic [15:0] mem_rdata;
  logic unmapped_reg;

  // Request handshake
  assign req_ready = (state_reg == dphr_pkg::DPHR_IDLE);
  assign take = req_valid && req_ready;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      req_q_reg <= '0;
    end else if (take) begin
      req_q_reg <= req;
    end
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      dphr_pkg::DPHR_IDLE: begin
        if (take) begin
          state_next = dphr_pkg::DPHR_EXEC;
        end
      end
      dphr_pkg::DPHR_EXEC: state_next = dphr_pkg::DPHR_RESP;
      dphr_pkg::DPHR_RESP: state_next = dphr_pkg::DPHR_IDLE;
      default: state_next = dphr_pkg::DPHR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= dphr_pkg::DPHR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Span check against the current limit words
  assign lim = '{
    start_freq: start_frequency_setting,
    max_m1: maximum_frequency_m1,
    max_m2: maximum_frequency_m2,
    upper_m1: ctrl.upper_m1,
    lower_m1: ctrl.lower_m1,
    upper_m2: ctrl.upper_m2,
    lower_m2: ctrl.lower_m2
  };

  dphr_range_check u_check (
    .addr(req_q_reg.addr),
    .data(req_q_reg.data),
    .lim(lim),
    .hit(chk_hit),
    .idx(chk_idx),
    .ok(chk_ok)
  );

  // Only in-span writes reach the store
  assign commit = (state_reg == dphr_pkg::DPHR_EXEC) && req_q_reg.write && chk_ok;
  assign rd_fetch = (state_reg == dphr_pkg::DPHR_EXEC) && !req_q_reg.write && chk_hit;

  dphr_word_mem #(
    .DEPTH(DEPTH)
  ) u_mem (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_en(commit),
    .wr_idx(chk_idx),
    .wr_data(req_q_reg.data),
    .rd_en(rd_fetch),
    .rd_idx(chk_idx),
    .rd_data(mem_rdata)
  );

  // Working copies of the words that steer the drive
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl <= '0;
    end else if (commit) begin
      unique case (req_q_reg.addr)
        dphr_pkg::ADR_BRK_SEL: ctrl.brake_select <= req_q_reg.data[1:0];
        dphr_pkg::ADR_BRK_TRIG: ctrl.brake_level_sense <= req_q_reg.data[0];
        dphr_pkg::ADR_LOOP_EN: ctrl.loop_enable <= req_q_reg.data[0];
        dphr_pkg::ADR_PV_SRC: ctrl.pv_source <= req_q_reg.data[1:0];
        dphr_pkg::ADR_LOOP_DIR: ctrl.loop_negate <= req_q_reg.data[0];
        dphr_pkg::ADR_VREG_SEL: ctrl.volt_reg_select <= req_q_reg.data[1:0];
        dphr_pkg::ADR_UPPER_M1: ctrl.upper_m1 <= req_q_reg.data;
        dphr_pkg::ADR_LOWER_M1: ctrl.lower_m1 <= req_q_reg.data;
        dphr_pkg::ADR_UPPER_M2: ctrl.upper_m2 <= req_q_reg.data;
        dphr_pkg::ADR_LOWER_M2: ctrl.lower_m2 <= req_q_reg.data;
        default: ;
      endcase
    end
  end

  // Answer status, decided while executing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      resp_status <= dphr_pkg::DPHR_OK;
      unmapped_reg <= 1'b0;
    end else if (state_reg == dphr_pkg::DPHR_EXEC) begin
      unmapped_reg <= !chk_hit;
      if (!chk_hit) begin
        resp_status <= dphr_pkg::DPHR_UNMAPPED;
      end else if (req_q_reg.write && !chk_ok) begin
        resp_status <= dphr_pkg::DPHR_REFUSED;
      end else begin
        resp_status <= dphr_pkg::DPHR_OK;
      end
    end
  end

  // Read data straight from the store, zero for unmapped words
  assign resp_valid = (state_reg == dphr_pkg::DPHR_RESP);
  assign resp_rdata = unmapped_reg ? '0 : mem_rdata;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_take_rd;
    take && !req.write;
  endsequence

  sequence s_take_wr(logic [15:0] a);
    take && req.write && req.addr == a;
  endsequence

  sequence s_answer_refused;
    resp_valid && resp_status == dphr_pkg::DPHR_REFUSED;
  endsequence

  property p_over(logic [15:0] a, logic [15:0] mx);
    s_take_wr(a) ##0 req.data > mx |-> ##2 s_answer_refused;
  endproperty

  property p_under(logic [15:0] a, logic [15:0] mn);
    s_take_wr(a) ##0 req.data < mn |-> ##2 s_answer_refused;
  endproperty

  read_answer_a: assert property (s_take_rd |-> ##2 resp_valid ##1 !resp_valid)
    else $error("read answer not two cycles after take");

  brake_readback_a: assert property (
    s_take_rd ##0 req.addr == dphr_pkg::ADR_BRK_SEL
    |-> ##2 resp_rdata == {14'h0000, ctrl.brake_select})
    else $error("brake select read back differs from stored code");

  brake_code_a: assert property (ctrl.brake_select != 2'h3)
    else $error("brake select holds an invalid code");

  onset_span_a: assert property (p_over(dphr_pkg::ADR_BRK_ONSET, dphr_pkg::MAX_BRK_ONSET))
    else $error("onset above 600 not refused");

  wait_span_a: assert property (p_over(dphr_pkg::ADR_BRK_WAIT, dphr_pkg::MAX_BRK_WAIT))
    else $error("wait above 50 not refused");

  force_span_a: assert property (p_over(dphr_pkg::ADR_BRK_FORCE, dphr_pkg::MAX_BRK_FORCE))
    else $error("force above 100 not refused");

  brake_time_a: assert property (p_over(dphr_pkg::ADR_BRK_TIME, dphr_pkg::MAX_BRK_TIME))
    else $error("duration above 600 not refused");

  trig_keep_a: assert property (
    s_take_wr(dphr_pkg::ADR_BRK_TRIG) ##0 req.data > dphr_pkg::MAX_CODE2
    |-> ##1 $stable(ctrl.brake_level_sense) [*2])
    else $error("bad trigger code changed sensing mode");

  upper_keep_a: assert property (
    s_take_wr(dphr_pkg::ADR_UPPER_M1) ##0 req.data > maximum_frequency_m1
    ##1 $stable(maximum_frequency_m1) |-> ##1 $stable(ctrl.upper_m1))
    else $error("upper limit above maximum was stored");

  limit_order_a: assert property (
    ctrl.lower_m1 == '0 || ctrl.upper_m1 == '0 || ctrl.lower_m1 <= ctrl.upper_m1)
    else $error("motor 1 lower limit above upper limit");

  limit2_order_a: assert property (
    ctrl.lower_m2 == '0 || ctrl.upper_m2 == '0 || ctrl.lower_m2 <= ctrl.upper_m2)
    else $error("motor 2 lower limit above upper limit");

  lower2_zero_a: assert property (
    s_take_wr(dphr_pkg::ADR_LOWER_M2) ##0 req.data == '0
    |-> ##2 resp_status == dphr_pkg::DPHR_OK ##0 ctrl.lower_m2 == '0)
    else $error("zero did not disable motor 2 lower limit");

  jump_ctr_a: assert property (p_over(dphr_pkg::ADR_JCTR_2, dphr_pkg::MAX_JUMP_CTR))
    else $error("jump centre above 4000 not refused");

  jump_wid_a: assert property (p_over(dphr_pkg::ADR_JWID_3, dphr_pkg::MAX_JUMP_WID))
    else $error("jump width above 100 not refused");

  loop_int_a: assert property (p_over(dphr_pkg::ADR_LOOP_INT, dphr_pkg::MAX_LOOP_INT))
    else $error("integral time above 1500 not refused");

  loop_der_a: assert property (p_over(dphr_pkg::ADR_LOOP_DER, dphr_pkg::MAX_LOOP_DER))
    else $error("derivative time above 1000 not refused");

  pv_scale_lo_a: assert property (p_under(dphr_pkg::ADR_PV_SCALE, dphr_pkg::MIN_PV_SCALE))
    else $error("scale of zero not refused");

  pv_scale_hi_a: assert property (p_over(dphr_pkg::ADR_PV_SCALE, dphr_pkg::MAX_PV_SCALE))
    else $error("scale above 9999 not refused");

  pv_source_a: assert property (p_over(dphr_pkg::ADR_PV_SRC, dphr_pkg::MAX_PV_SRC))
    else $error("source above 3 not refused");

  loop_dir_a: assert property (
    s_take_wr(dphr_pkg::ADR_LOOP_DIR) ##0 req.data == 16'h0001
    |-> ##2 ctrl.loop_negate)
    else $error("loop direction 1 did not negate");

  loop_lim_a: assert property (p_over(dphr_pkg::ADR_LOOP_LIM, dphr_pkg::MAX_LOOP_LIM))
    else $error("loop limit above 1000 not refused");

  volt_code_a: assert property (ctrl.volt_reg_select != 2'h3)
    else $error("voltage regulation holds an invalid code");

  energy_span_a: assert property (p_over(dphr_pkg::ADR_ENERGY, dphr_pkg::MAX_ENERGY))
    else $error("energy tuning above 1000 not refused");

  brake_sel_a: assert property (
    p_over(dphr_pkg::ADR_BRK_SEL, dphr_pkg::MAX_CODE3))
    else $error("brake code above 2 not refused");

  trig_code_a: assert property (
    p_over(dphr_pkg::ADR_BRK_TRIG, dphr_pkg::MAX_CODE2))
    else $error("trigger code above 1 not refused");

  jump_ctr1_a: assert property (
    p_over(dphr_pkg::ADR_JCTR_1, dphr_pkg::MAX_JUMP_CTR))
    else $error("jump centre 1 not refused");

  jump_ctr3_a: assert property (
    p_over(dphr_pkg::ADR_JCTR_3, dphr_pkg::MAX_JUMP_CTR))
    else $error("jump centre 3 not refused");

  jump_wid1_a: assert property (
    p_over(dphr_pkg::ADR_JWID_1, dphr_pkg::MAX_JUMP_WID))
    else $error("jump width 1 not refused");

  jump_wid2_a: assert property (
    p_over(dphr_pkg::ADR_JWID_2, dphr_pkg::MAX_JUMP_WID))
    else $error("jump width 2 not refused");

  dir_code_a: assert property (
    p_over(dphr_pkg::ADR_LOOP_DIR, dphr_pkg::MAX_CODE2))
    else $error("direction code above 1 not refused");

  volt_sel_a: assert property (
    p_over(dphr_pkg::ADR_VREG_SEL, dphr_pkg::MAX_CODE3))
    else $error("regulation code above 2 not refused");

  gain_hi_a: assert property (
    p_over(dphr_pkg::ADR_LOOP_GAIN, dphr_pkg::MAX_LOOP_GAIN))
    else $error("gain above 50 not refused");

  gain_lo_a: assert property (
    p_under(dphr_pkg::ADR_LOOP_GAIN, dphr_pkg::MIN_LOOP_GAIN))
    else $error("gain below 2 not refused");

  volt_lvl_a: assert property (
    p_over(dphr_pkg::ADR_VREG_LVL, dphr_pkg::MAX_VREG_LVL))
    else $error("voltage level above 5 not refused");

  op_mode_a: assert property (
    p_over(dphr_pkg::ADR_OP_MODE, dphr_pkg::MAX_CODE2))
    else $error("mode code above 1 not refused");

  loop_en_a: assert property (
    p_over(dphr_pkg::ADR_LOOP_EN, dphr_pkg::MAX_CODE2))
    else $error("enable code above 1 not refused");

  answer_pulse_a: assert property (
    resp_valid |=> !resp_valid && req_ready)
    else $error("answer stood longer than one cycle");

  refuse_keep_a: assert property (
    state_reg == dphr_pkg::DPHR_EXEC && req_q_reg.write && !chk_ok
    |=> $stable(ctrl) && resp_status != dphr_pkg::DPHR_OK)
    else $error("refused write changed stored settings");
endmodule : dphr_holding_regs

/* verilog/dphr_pkg.sv */
// Shared constants and types of the drive parameter holding registers
package dphr_pkg;
  localparam int REG_NUM = 28;
  localparam int IDX_W = 5;
  // Word addresses
  localparam logic [15:0] ADR_BRK_SEL = 16'h1051;
  localparam logic [15:0] ADR_BRK_ONSET = 16'h1052;
  localparam logic [15:0] ADR_BRK_WAIT = 16'h1053;
  localparam logic [15:0] ADR_BRK_FORCE = 16'h1054;
  localparam logic [15:0] ADR_BRK_TIME = 16'h1055;
  localparam logic [15:0] ADR_BRK_TRIG = 16'h1056;
  localparam logic [15:0] ADR_UPPER_M1 = 16'h105A;
  localparam logic [15:0] ADR_LOWER_M1 = 16'h105B;
  localparam logic [15:0] ADR_JCTR_1 = 16'h105D;
  localparam logic [15:0] ADR_JWID_1 = 16'h105E;
  localparam logic [15:0] ADR_JCTR_2 = 16'h1060;
  localparam logic [15:0] ADR_JWID_2 = 16'h1061;
  localparam logic [15:0] ADR_JCTR_3 = 16'h1063;
  localparam logic [15:0] ADR_JWID_3 = 16'h1064;
  localparam logic [15:0] ADR_LOOP_EN = 16'h1068;
  localparam logic [15:0] ADR_LOOP_GAIN = 16'h1069;
  localparam logic [15:0] ADR_LOOP_INT = 16'h106A;
  localparam logic [15:0] ADR_LOOP_DER = 16'h106B;
  localparam logic [15:0] ADR_PV_SCALE = 16'h106C;
  localparam logic [15:0] ADR_PV_SRC = 16'h106D;
  localparam logic [15:0] ADR_LOOP_DIR = 16'h106E;
  localparam logic [15:0] ADR_LOOP_LIM = 16'h106F;
  localparam logic [15:0] ADR_VREG_SEL = 16'h1070;
  localparam logic [15:0] ADR_VREG_LVL = 16'h1071;
  localparam logic [15:0] ADR_OP_MODE = 16'h1072;
  localparam logic [15:0] ADR_ENERGY = 16'h1073;
  localparam logic [15:0] ADR_UPPER_M2 = 16'h1517;
  localparam logic [15:0] ADR_LOWER_M2 = 16'h1518;
  localparam logic [15:0] REG_ADDR [REG_NUM] = '{
    ADR_BRK_SEL, ADR_BRK_ONSET, ADR_BRK_WAIT, ADR_BRK_FORCE, ADR_BRK_TIME,
    ADR_BRK_TRIG, ADR_UPPER_M1, ADR_LOWER_M1, ADR_JCTR_1, ADR_JWID_1,
    ADR_JCTR_2, ADR_JWID_2, ADR_JCTR_3, ADR_JWID_3, ADR_LOOP_EN,
    ADR_LOOP_GAIN, ADR_LOOP_INT, ADR_LOOP_DER, ADR_PV_SCALE, ADR_PV_SRC,
    ADR_LOOP_DIR, ADR_LOOP_LIM, ADR_VREG_SEL, ADR_VREG_LVL, ADR_OP_MODE,
    ADR_ENERGY, ADR_UPPER_M2, ADR_LOWER_M2};
  // Reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_PV_SCALE = 16'h0064;
  // Valid spans
  localparam logic [15:0] MAX_CODE3 = 16'h0002;
  localparam logic [15:0] MAX_CODE2 = 16'h0001;
  localparam logic [15:0] MAX_PV_SRC = 16'h0003;
  localparam logic [15:0] MAX_BRK_ONSET = 16'h0258;
  localparam logic [15:0] MAX_BRK_WAIT = 16'h0032;
  localparam logic [15:0] MAX_BRK_FORCE = 16'h0064;
  localparam logic [15:0] MAX_BRK_TIME = 16'h0258;
  localparam logic [15:0] MAX_JUMP_CTR = 16'h0FA0;
  localparam logic [15:0] MAX_JUMP_WID = 16'h0064;
  localparam logic [15:0] MIN_LOOP_GAIN = 16'h0002;
  localparam logic [15:0] MAX_LOOP_GAIN = 16'h0032;
  localparam logic [15:0] MAX_LOOP_INT = 16'h05DC;
  localparam logic [15:0] MAX_LOOP_DER = 16'h03E8;
  localparam logic [15:0] MIN_PV_SCALE = 16'h0001;
  localparam logic [15:0] MAX_PV_SCALE = 16'h270F;
  localparam logic [15:0] MAX_LOOP_LIM = 16'h03E8;
  localparam logic [15:0] MAX_VREG_LVL = 16'h0005;
  localparam logic [15:0] MAX_ENERGY = 16'h03E8;

  typedef enum logic [1:0] {
    DPHR_OK = 2'h0, DPHR_REFUSED = 2'h1, DPHR_UNMAPPED = 2'h2
  } dphr_status_t;
  typedef enum logic [1:0] {
    DPHR_IDLE = 2'h0, DPHR_EXEC = 2'h1, DPHR_RESP = 2'h3
  } dphr_state_t;
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [15:0] data;
  } dphr_req_t;
  typedef struct packed {
    logic [15:0] start_freq;
    logic [15:0] max_m1;
    logic [15:0] max_m2;
    logic [15:0] upper_m1;
    logic [15:0] lower_m1;
    logic [15:0] upper_m2;
    logic [15:0] lower_m2;
  } dphr_limits_t;
  typedef struct packed {
    logic [1:0] brake_select;
    logic brake_level_sense;
    logic loop_enable;
    logic [1:0] pv_source;
    logic loop_negate;
    logic [1:0] volt_reg_select;
    logic [15:0] upper_m1;
    logic [15:0] lower_m1;
    logic [15:0] upper_m2;
    logic [15:0] lower_m2;
  } dphr_ctrl_t;

  // Address to {hit, index}
  function automatic logic [IDX_W:0] addr_lookup(input logic [15:0] addr);
    logic [IDX_W:0] res;
    res = '0;
    for (int i = 0; i < REG_NUM; i++) begin
      if (REG_ADDR[i] == addr) begin
        res = {1'b1, IDX_W'(i)};
      end
    end
    return res;
  endfunction : addr_lookup

  function automatic logic [15:0] reset_value(input int idx);
    return (REG_ADDR[idx] == ADR_PV_SCALE) ? RST_PV_SCALE : RST_ZERO;
  endfunction : reset_value
endpackage : dphr_pkg

/* verilog/dphr_range_check.sv */
// Decodes a word address and checks a value against its span
`timescale 1ns/1ps
module dphr_range_check (
  // Candidate word
  input wire logic [15:0] addr,
  input wire logic [15:0] data,
  input wire dphr_pkg::dphr_limits_t lim,
  // Verdict
  output logic hit,
  output logic [dphr_pkg::IDX_W-1:0] idx,
  output logic ok
);
  logic [15:0] lo;
  logic [15:0] hi;
  logic zero_ok;

  assign {hit, idx} = dphr_pkg::addr_lookup(addr);

  always_comb begin
    lo = '0;
    hi = '0;
    zero_ok = 1'b0;
    unique case (addr)
      dphr_pkg::ADR_BRK_SEL, dphr_pkg::ADR_VREG_SEL: hi = dphr_pkg::MAX_CODE3;
      dphr_pkg::ADR_BRK_ONSET: begin
        lo = lim.start_freq;
        hi = dphr_pkg::MAX_BRK_ONSET;
      end
      dphr_pkg::ADR_BRK_WAIT: hi = dphr_pkg::MAX_BRK_WAIT;
      dphr_pkg::ADR_BRK_FORCE: hi = dphr_pkg::MAX_BRK_FORCE;
      dphr_pkg::ADR_BRK_TIME: hi = dphr_pkg::MAX_BRK_TIME;
      dphr_pkg::ADR_BRK_TRIG, dphr_pkg::ADR_LOOP_EN, dphr_pkg::ADR_LOOP_DIR,
      dphr_pkg::ADR_OP_MODE: hi = dphr_pkg::MAX_CODE2;
      dphr_pkg::ADR_UPPER_M1: begin
        lo = lim.lower_m1;
        hi = lim.max_m1;
        zero_ok = 1'b1;
      end
      dphr_pkg::ADR_UPPER_M2: begin
        lo = lim.lower_m2;
        hi = lim.max_m2;
        zero_ok = 1'b1;
      end
      dphr_pkg::ADR_LOWER_M1: begin
        lo = lim.start_freq;
        hi = (lim.upper_m1 == '0) ? lim.max_m1 : lim.upper_m1;
        zero_ok = 1'b1;
      end
      dphr_pkg::ADR_LOWER_M2: begin
        lo = lim.start_freq;
        hi = (lim.upper_m2 == '0) ? lim.max_m2 : lim.upper_m2;
        zero_ok = 1'b1;
      end
      dphr_pkg::ADR_JCTR_1, dphr_pkg::ADR_JCTR_2,
      dphr_pkg::ADR_JCTR_3: hi = dphr_pkg::MAX_JUMP_CTR;
      dphr_pkg::ADR_JWID_1, dphr_pkg::ADR_JWID_2,
      dphr_pkg::ADR_JWID_3: hi = dphr_pkg::MAX_JUMP_WID;
      dphr_pkg::ADR_LOOP_GAIN: begin
        lo = dphr_pkg::MIN_LOOP_GAIN;
        hi = dphr_pkg::MAX_LOOP_GAIN;
      end
      dphr_pkg::ADR_LOOP_INT: hi = dphr_pkg::MAX_LOOP_INT;
      dphr_pkg::ADR_LOOP_DER: hi = dphr_pkg::MAX_LOOP_DER;
      dphr_pkg::ADR_PV_SCALE: begin
        lo = dphr_pkg::MIN_PV_SCALE;
        hi = dphr_pkg::MAX_PV_SCALE;
      end
      dphr_pkg::ADR_PV_SRC: hi = dphr_pkg::MAX_PV_SRC;
      dphr_pkg::ADR_LOOP_LIM: hi = dphr_pkg::MAX_LOOP_LIM;
      dphr_pkg::ADR_VREG_LVL: hi = dphr_pkg::MAX_VREG_LVL;
      dphr_pkg::ADR_ENERGY: hi = dphr_pkg::MAX_ENERGY;
      default: ;
    endcase
  end

  assign ok = hit && ((data >= lo && data <= hi) || (zero_ok && data == '0));
endmodule : dphr_range_check

/* verilog/dphr_word_mem.sv */
// Parameter word store with registered read port
`timescale 1ns/1ps
module dphr_word_mem #(
  parameter int DEPTH = dphr_pkg::REG_NUM
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Write port
  input wire logic wr_en,
  input wire logic [dphr_pkg::IDX_W-1:0] wr_idx,
  input wire logic [15:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [dphr_pkg::IDX_W-1:0] rd_idx,
  output logic [15:0] rd_data
);
  logic [15:0] mem_reg [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= dphr_pkg::reset_value(i);
      end
    end else if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_reg[rd_idx];
    end
  end
endmodule : dphr_word_mem
